//--- period_match_timer_defs.vh
// Constants for the period match timer: offsets, fields, reset values
`ifndef PERIOD_MATCH_TIMER_DEFS_VH
`define PERIOD_MATCH_TIMER_DEFS_VH

`define OFF_COUNT        12'h000
`define OFF_PERIOD       12'h004
`define OFF_CONTROL      12'h008
`define OFF_IRQ_STATUS   12'h00c
`define OFF_IRQ_MASK     12'h010

`define RST_COUNT        8'h00
`define RST_PERIOD       8'hff
`define RST_CONTROL      8'h00

`define CTL_PRE_LSB      0
`define CTL_PRE_MSB      1
`define CTL_RUN_BIT      2
`define CTL_POST_LSB     3
`define CTL_POST_MSB     6
`define CTL_WMASK        8'h7f

`define PRE_DIV4_LAST    4'h3
`define PRE_DIV16_LAST   4'hf

`endif

//--- period_match_timer_8bit.v
// Top module of the 8-bit period match timer with APB register access
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`default_nettype none
`include "period_match_timer_defs.vh"

module period_match_timer_8bit (
    input  wire        CORE_CLK,
    input  wire        RESET,
    input  wire        QUARTER_TICK,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    input  wire [3:0]  PSTRB,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    output reg         IRQ,
    output reg         SERIAL_SHIFT_TICK,
    output reg         PWM_TIMEBASE_TICK
);

    // ****************************************
    // Input synchroniser
    // ****************************************
    // Quarter tick comes from the oscillator divider outside this domain
    reg        tick_meta_reg;
    reg        tick_sync_reg;
    reg        tick_prev_reg;
    wire       tick_rise;

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            tick_meta_reg <= 1'b0;
            tick_sync_reg <= 1'b0;
        end else begin
            tick_meta_reg <= QUARTER_TICK;
            tick_sync_reg <= tick_meta_reg;
        end
    end

    // Edge detector resets to the idle low level of the pin, so no false edge follows reset
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            tick_prev_reg <= 1'b0;
        end else begin
            tick_prev_reg <= tick_sync_reg;
        end
    end

    assign tick_rise = tick_sync_reg & ~tick_prev_reg;

    // ****************************************
    // Register bus decode
    // ****************************************
    reg  [7:0] count_reg;
    reg  [7:0] period_reg;
    reg  [7:0] control_reg;
    reg        flag_reg;
    reg        mask_reg;
    reg  [3:0] pre_cnt_reg;
    reg  [3:0] post_cnt_reg;

    wire       access;
    wire       wr;
    wire       lane0;
    wire       hit_count;
    wire       hit_period;
    wire       hit_control;
    wire       hit_status;
    wire       hit_mask;
    wire       mapped;

    // Single cycle access phase: pready is high in every access cycle
    assign access      = PSEL & PENABLE;
    assign wr          = access & PWRITE;
    assign lane0       = PSTRB[0];
    assign hit_count   = (PADDR == `OFF_COUNT);
    assign hit_period  = (PADDR == `OFF_PERIOD);
    assign hit_control = (PADDR == `OFF_CONTROL);
    assign hit_status  = (PADDR == `OFF_IRQ_STATUS);
    assign hit_mask    = (PADDR == `OFF_IRQ_MASK);
    assign mapped      = hit_count | hit_period | hit_control | hit_status | hit_mask;

    wire       wr_count   = wr & hit_count & lane0;
    wire       wr_control = wr & hit_control & lane0;
    wire       wr_period  = wr & hit_period & lane0;
    wire       wr_mask    = wr & hit_mask & lane0;
    wire       wr_status  = wr & hit_status & lane0;
    wire       setup      = PSEL & ~PENABLE;
    wire       rd_setup   = setup & ~PWRITE;

    reg  [31:0] rdata_next;

    always @* begin
        rdata_next = 32'h0000_0000;
        if (hit_count) begin
            rdata_next = {24'h00_0000, count_reg};
        end else if (hit_period) begin
            rdata_next = {24'h00_0000, period_reg};
        end else if (hit_control) begin
            rdata_next = {24'h00_0000, control_reg};
        end else if (hit_status) begin
            rdata_next = {31'h0000_0000, flag_reg};
        end else if (hit_mask) begin
            rdata_next = {31'h0000_0000, mask_reg};
        end
    end

    // ****************************************
    // Bus answer
    // ****************************************
    // No wait states: ready follows every setup cycle, so the master never stalls here
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= setup;
        end
    end

    // An unmapped address answers with an error and leaves every register alone
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            PSLVERR <= 1'b0;
        end else begin
            PSLVERR <= setup & ~mapped;
        end
    end

    // Read data is sampled at the setup edge and stands until the next read
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_setup) begin
            PRDATA <= rdata_next;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    // A period written below the running count is only met after the count wraps past ffh
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            period_reg <= `RST_PERIOD;
        end else if (wr_period) begin
            period_reg <= PWDATA[7:0];
        end
    end

    // Bit 7 is never stored, so it reads back as zero whatever was written
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            control_reg <= `RST_CONTROL;
        end else if (wr_control) begin
            control_reg <= PWDATA[7:0] & `CTL_WMASK;
        end
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            mask_reg <= 1'b0;
        end else if (wr_mask) begin
            mask_reg <= PWDATA[0];
        end
    end

    // ****************************************
    // Timer fields and internal signals
    // ****************************************
    wire [1:0] pre_sel  = control_reg[`CTL_PRE_MSB:`CTL_PRE_LSB];
    wire [3:0] post_sel = control_reg[`CTL_POST_MSB:`CTL_POST_LSB];
    wire       running  = control_reg[`CTL_RUN_BIT];
    reg  [3:0] pre_last;
    reg  [3:0] pre_cnt_next;
    reg  [7:0] count_next;
    reg  [3:0] post_cnt_next;
    reg        flag_next;
    wire [3:0] pre_cnt_inc;
    wire [7:0] count_inc;
    wire [3:0] post_cnt_inc;
    wire       scaler_clr;
    wire       run_tick;
    wire       pre_tick;
    wire       at_period;
    wire       match;
    wire       post_done;
    wire       clr_flag;

    // ****************************************
    // Scaler restart
    // ****************************************
    // Either software write restarts both scalers at once
    assign scaler_clr = wr_count | wr_control;

    // ****************************************
    // Prescaler
    // ****************************************
    always @* begin
        pre_last = 4'h0;
        if (pre_sel[1]) begin
            pre_last = `PRE_DIV16_LAST;
        end else if (pre_sel[0]) begin
            pre_last = `PRE_DIV4_LAST;
        end
    end

    // An input tick that meets a count or control write is dropped, so the write restarts cleanly
    assign run_tick    = running & tick_rise & ~scaler_clr;
    assign pre_tick    = run_tick & (pre_cnt_reg == pre_last);
    assign pre_cnt_inc = pre_cnt_reg + 4'h1;

    always @* begin
        pre_cnt_next = pre_cnt_reg;
        if (scaler_clr) begin
            pre_cnt_next = 4'h0;
        end else if (pre_tick) begin
            pre_cnt_next = 4'h0;
        end else if (run_tick) begin
            pre_cnt_next = pre_cnt_inc;
        end
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            pre_cnt_reg <= 4'h0;
        end else begin
            pre_cnt_reg <= pre_cnt_next;
        end
    end

    // ****************************************
    // Period counter
    // ****************************************
    assign at_period = (count_reg == period_reg);
    assign match     = pre_tick & at_period;
    assign count_inc = count_reg + 8'h01;

    // A software load wins over the reload and the increment of the same cycle
    always @* begin
        count_next = count_reg;
        if (wr_count) begin
            count_next = PWDATA[7:0];
        end else if (wr_control) begin
            count_next = count_reg;
        end else if (match) begin
            count_next = 8'h00;
        end else if (pre_tick) begin
            count_next = count_inc;
        end
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            count_reg <= `RST_COUNT;
        end else begin
            count_reg <= count_next;
        end
    end

    // ****************************************
    // Postscaler
    // ****************************************
    // Code n lets n+1 matches through per flag, so four bits reach one in sixteen
    assign post_done    = match & (post_cnt_reg == post_sel);
    assign post_cnt_inc = post_cnt_reg + 4'h1;

    always @* begin
        post_cnt_next = post_cnt_reg;
        if (scaler_clr) begin
            post_cnt_next = 4'h0;
        end else if (post_done) begin
            post_cnt_next = 4'h0;
        end else if (match) begin
            post_cnt_next = post_cnt_inc;
        end
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            post_cnt_reg <= 4'h0;
        end else begin
            post_cnt_reg <= post_cnt_next;
        end
    end

    // ****************************************
    // Match flag
    // ****************************************
    assign clr_flag = wr_status & PWDATA[0];

    // Set beats clear so a post_done in the clearing cycle is kept
    always @* begin
        flag_next = flag_reg;
        if (post_done) begin
            flag_next = 1'b1;
        end else if (clr_flag) begin
            flag_next = 1'b0;
        end
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // ****************************************
    // Interrupt request
    // ****************************************
    // Registered so the output comes from a flip-flop, one cycle behind the flag and mask
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= flag_reg & mask_reg;
        end
    end

    // ****************************************
    // Exported ticks
    // ****************************************
    // Taken before the postscaler: one pulse per period match
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            SERIAL_SHIFT_TICK <= 1'b0;
        end else begin
            SERIAL_SHIFT_TICK <= match;
        end
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            PWM_TIMEBASE_TICK <= 1'b0;
        end else begin
            PWM_TIMEBASE_TICK <= match;
        end
    end

endmodule // period_match_timer_8bit
`default_nettype wire

//--- period_match_timer_sva.sv
// Checker of the period match timer bus and tick outputs
`default_nettype none
module period_match_timer_sva (
    input wire logic        CORE_CLK,
    input wire logic        RESET,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        SERIAL_SHIFT_TICK,
    input wire logic        PWM_TIMEBASE_TICK
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Properties
    // ****
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    sequence setup_s; PSEL && !PENABLE; endsequence
    sequence read_s; PREADY && !PWRITE; endsequence
    // Zero wait states, so a late ready is a decode fault
    ready_after_a: assert property (setup_s |=> PREADY && PENABLE) else $error("ready missing");
    ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
    err_unmapped_a: assert property (setup_s ##0 PADDR > 12'h010 |=> PSLVERR) else $error("no slave error");
    err_mapped_a: assert property (PREADY && PADDR <= 12'h010 && PADDR[1:0] == 2'b00 |-> !PSLVERR)
        else $error("bad slave error");
    upper_zero_a: assert property (read_s |-> PRDATA[31:8] == 24'h000000) else $error("upper bits set");
    bit7_zero_a: assert property (read_s ##0 PADDR == 12'h008 |-> !PRDATA[7]) else $error("bit 7 set");
    tick_same_a: assert property (SERIAL_SHIFT_TICK == PWM_TIMEBASE_TICK) else $error("ticks differ");
    tick_pulse_a: assert property (SERIAL_SHIFT_TICK |=> !SERIAL_SHIFT_TICK) else $error("tick too long");
endmodule // period_match_timer_sva
bind period_match_timer_8bit period_match_timer_sva sva_inst (.CORE_CLK, .RESET, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PRDATA, .PREADY, .PSLVERR, .SERIAL_SHIFT_TICK, .PWM_TIMEBASE_TICK);
`default_nettype wire

//--- period_match_timer_8bit_tb_top.sv
// Testbench of the period match timer
`default_nettype none
`include "period_match_timer_defs.vh"
module period_match_timer_8bit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, qt = 0, psel = 0, pen = 0, pw = 0, err;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, irq, sst, pwt;
    int n_errors = 0, samples_checked = 0, cyc = 0, nt = 0;
    always #2 clk = ~clk;
    period_match_timer_8bit period_match_timer_8bit_inst (.CORE_CLK(clk), .RESET(rst), .QUARTER_TICK(qt),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pw), .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hf), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .SERIAL_SHIFT_TICK(sst), .PWM_TIMEBASE_TICK(pwt));
    // ****
    // Tasks
    // ****
    task finish_test;
        $display("Mismatches %0d of %0d checks", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sst === 1'b1)
            nt <= nt + 1;
        if (cyc == 20000) begin
            n_errors++;
            finish_test;
        end
    end
    task chk(input string nm, input logic [31:0] ex, got);
        samples_checked++;
        if (got !== ex) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // Request held until ready is seen, then an idle edge before the next one
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pen, pw, pa, pwd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task rc(input string nm, input logic [11:0] a, input logic [31:0] ex);
        apb(0, a, 0);
        chk(nm, ex, rd);
    endtask
    // Input ticks stay high and low two cycles each, then settle past the synchroniser
    task tk(input int n);
        repeat (n) begin
            qt <= 1;
            repeat (2) @(posedge clk);
            qt <= 0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
    // ****
    // Tests
    // ****
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rc("count", `OFF_COUNT, 0);
        rc("period", `OFF_PERIOD, 32'hff);
        rc("control", `OFF_CONTROL, 0);
        rc("unmapped", 12'h020, 0);
        chk("slverr", 1, err);
        wr(`OFF_CONTROL, 32'hff);
        rc("control", `OFF_CONTROL, 32'h7f);
        for (int p = 0; p < 4; p++) begin
            wr(`OFF_CONTROL, 4 + p);
            wr(`OFF_COUNT, 0);
            tk(p == 0 ? 0 : (p == 1 ? 3 : 15));
            rc("pre", `OFF_COUNT, 0);
            tk(1);
            rc("pre", `OFF_COUNT, 1);
        end
        wr(`OFF_CONTROL, 0);
        rc("held", `OFF_COUNT, 1);
        tk(2);
        rc("stopped", `OFF_COUNT, 1);
        wr(`OFF_CONTROL, 5);
        wr(`OFF_COUNT, 0);
        tk(3);
        wr(`OFF_CONTROL, 5);
        tk(3);
        rc("ctl clr", `OFF_COUNT, 0);
        wr(`OFF_COUNT, 5);
        rc("load", `OFF_COUNT, 5);
        wr(`OFF_PERIOD, 2);
        wr(`OFF_IRQ_MASK, 1);
        wr(`OFF_CONTROL, 32'h0c);
        wr(`OFF_COUNT, 0);
        tk(3);
        chk("ticks", 1, nt);
        rc("flag", `OFF_IRQ_STATUS, 0);
        tk(3);
        rc("flag", `OFF_IRQ_STATUS, 1);
        chk("irq", 1, irq);
        rc("wrap", `OFF_COUNT, 0);
        wr(`OFF_IRQ_MASK, 0);
        rc("sticky", `OFF_IRQ_STATUS, 1);
        chk("irq", 0, irq);
        wr(`OFF_IRQ_STATUS, 1);
        rc("clear", `OFF_IRQ_STATUS, 0);
        finish_test;
    end
endmodule // period_match_timer_8bit_tb_top
`default_nettype wire
